// >>> rtl/ckbd_pkg.sv
package ckbd_pkg;
   // Register offsets are word indices; byte address is index * 4
   localparam logic [7:0] CKBD_IDX_BAUD = 8'h3b;
   localparam logic [7:0] CKBD_IDX_TRIM = 8'h3c;
   localparam logic [7:0] CKBD_IDX_PLLC = 8'h3d;
   localparam logic [7:0] CKBD_IDX_PDIV = 8'h3e;
   localparam logic [7:0] CKBD_IDX_STAT = 8'h3f;
   localparam int CKBD_ADDR_W = 10;
   localparam logic [7:0] CKBD_BAUD_RST = 8'h7a;
   localparam logic [7:0] CKBD_TRIM_RST = 8'h80;
   localparam logic [7:0] CKBD_PLLC_RST = 8'h00;
   localparam logic [7:0] CKBD_PDIV_RST = 8'h08;
   localparam logic [7:0] CKBD_PDIV_MIN = 8'h08;
   localparam logic [7:0] CKBD_PDIV_MAX = 8'hfe;
   localparam int CKBD_EXP_HI = 7;
   localparam int CKBD_EXP_LO = 5;
   localparam int CKBD_MANT_HI = 4;
   localparam int CKBD_SEL_HI = 7;
   localparam int CKBD_SEL_LO = 4;
   localparam int CKBD_EN_BIT = 3;
   localparam int CKBD_PD_BIT = 2;
   localparam logic [15:0] CKBD_MANT_OFS = 16'h0021;
   localparam logic [5:0] CKBD_FB_23 = 6'h17;
   localparam logic [5:0] CKBD_FB_27 = 6'h1b;
   localparam logic [5:0] CKBD_FB_28 = 6'h1c;
   localparam int CKBD_TIMERS = 4;
   typedef enum logic [3:0]
   {
      CKBD_SRC_GPIO = 4'h0,
      CKBD_SRC_PLL = 4'h1,
      CKBD_SRC_LOW = 4'h2,
      CKBD_SRC_HIGH = 4'h3,
      CKBD_SRC_X1 = 4'h4,
      CKBD_SRC_X2 = 4'h5,
      CKBD_SRC_X4 = 4'h6,
      CKBD_SRC_X8 = 4'h7,
      CKBD_SRC_T0 = 4'h8,
      CKBD_SRC_T1 = 4'h9,
      CKBD_SRC_T2 = 4'ha,
      CKBD_SRC_T3 = 4'hb
   } ckbd_src_t;
   typedef struct packed
   {
      logic [2:0] baud_exponent;
      logic [4:0] baud_mantissa;
   } ckbd_baud_t;
   typedef struct packed
   {
      logic [3:0] clock_pin_source_select;
      logic clock_pin_drive_enable;
      logic pll_power_down;
      logic [1:0] pll_feedback_divider;
   } ckbd_pllc_t;
endpackage

// >>> rtl/ckbd_div.sv
`timescale 1ns/1ps
`default_nettype none
module ckbd_div import ckbd_pkg::*;
#(
   parameter int W = 16
)
(
   input wire logic sys_clk_in, // System clock
   input wire logic resetn_in, // Async reset, active low
   input wire logic [W-1:0] ratio_in, // Divide ratio, period in cycles
   output logic tick_out // One-cycle pulse each period
);
   logic [W-1:0] cnt;
   wire logic wrap = (cnt >= ratio_in - W'(1));
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cnt <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         cnt <= wrap ? '0 : cnt + W'(1);
         tick_out <= wrap;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ckbd_clock_and_baud_config.sv
// Functional notes
// RL1: Baud period is mantissa+1 crystal cycles at exponent zero, else (mantissa+33)*2^(exp-1).
// RL2: Host characters are one start, eight data, one stop bit with no parity.
// RL3: Software must not program a rate above 1228.8 kbit/s.
// RL4: The baud setting register resets to 7A.
// RL5: Table values EB, 7A and 15 give 9.6, 115.2 and 1228.8 kbit/s.
// RL6: The oscillator trim is an eight-bit read/write value; higher means slower.
// RL7: PLL output is crystal times feedback factor halved, then divided by output ratio.
// RL8: Source codes 0 to 3 give general I/O, PLL output, constant low, constant high.
// RL9: Source codes 4 to 7 give crystal divided by 1, 2, 4 and 8; code 4 drives xdiv[0], crystal divided by 2 like code 5.
// RL10: Source codes 8 to B toggle on timer 0 to 3 overflow; C to F are reserved.
// RL11: Control bit 3 enables the clock on the pin; clear means no clock driven.
// RL12: Feedback code 00 and 11 give 23, 01 gives 27, 10 gives 28.
// RL13: Output ratio divides by its value for 8 to 254; 0 to 7 reserved.
// RL14: Baud exponent is bits 7 to 5, mantissa bits 4 to 0.
// RL15: Control bit 2 powers the PLL down and stops its output.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ckbd_clock_and_baud_config import ckbd_pkg::*;
(
   input wire logic sys_clk_in, // Crystal-rate system clock
   input wire logic resetn_in, // Async reset, active low
   input wire logic wb_cyc_in, // Wishbone cycle
   input wire logic wb_stb_in, // Wishbone strobe
   input wire logic wb_we_in, // Wishbone write enable
   input wire logic [CKBD_ADDR_W-1:0] wb_adr_in, // Byte address
   input wire logic [3:0] wb_sel_in, // Byte lanes
   input wire logic [31:0] wb_dat_in, // Write data
   output logic [31:0] wb_dat_out, // Read data
   output logic wb_ack_out, // Acknowledge
   input wire logic [CKBD_TIMERS-1:0] timer_ovf_in, // Timer overflow pulses, same clock
   input wire logic pll_clk_in, // Analog PLL output, foreign clock
   input wire logic pin_gpio_in, // General I/O level for the pin
   output logic clock_output_pin_out, // Clock output pin level
   output logic clock_output_pin_oe_out, // Clock output pin enable
   output logic baud_tick_out, // One-cycle pulse per host bit time
   output logic [7:0] osc_trim_value_out, // Oscillator trim
   output logic [5:0] pll_fb_factor_out, // PLL feedback factor
   output logic [7:0] pll_out_ratio_out, // PLL output ratio
   output logic pll_power_down_out // PLL power down
);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   ckbd_baud_t baud;
   logic [7:0] osc_trim_value;
   ckbd_pllc_t pllc;
   logic [7:0] pdiv;
   wire logic [7:0] idx = wb_adr_in[CKBD_ADDR_W-1:2];
   wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic wr_lane = req && wb_we_in && wb_sel_in[0];
   wire logic wr_baud = wr_lane && (idx == CKBD_IDX_BAUD);
   wire logic wr_trim = wr_lane && (idx == CKBD_IDX_TRIM);
   wire logic wr_pllc = wr_lane && (idx == CKBD_IDX_PLLC);
   wire logic wr_pdiv = wr_lane && (idx == CKBD_IDX_PDIV);
   logic pll_seen;
   logic pdiv_bad_rd;
   wire logic [7:0] stat_val = {6'h00, pdiv_bad_rd, pll_seen};
   wire logic [7:0] rd_byte =
      (idx == CKBD_IDX_BAUD) ? baud :
      (idx == CKBD_IDX_TRIM) ? osc_trim_value :
      (idx == CKBD_IDX_PLLC) ? pllc :
      (idx == CKBD_IDX_PDIV) ? pdiv :
      (idx == CKBD_IDX_STAT) ? stat_val : 8'h00;
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         baud <= CKBD_BAUD_RST; // [RL4]
         osc_trim_value <= CKBD_TRIM_RST;
         pllc <= CKBD_PLLC_RST;
         pdiv <= CKBD_PDIV_RST;
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_out <= req;
         wb_dat_out <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         if (wr_baud)
            baud <= wb_dat_in[7:0]; // [RL14]
         if (wr_trim)
            osc_trim_value <= wb_dat_in[7:0]; // [RL6]
         if (wr_pllc)
            pllc <= wb_dat_in[7:0];
         if (wr_pdiv)
            pdiv <= wb_dat_in[7:0];
      end
   end
   // ----------------------------------------------------------------
   // Baud generator
   // ----------------------------------------------------------------
   // Bit period in crystal cycles; shift covers exponent up to 7
   wire logic [15:0] mant_wide = {11'h000, baud.baud_mantissa};
   wire logic [15:0] baud_ratio = (baud.baud_exponent == 3'h0) ?
      mant_wide + 16'h0001 :
      (mant_wide + CKBD_MANT_OFS) << (baud.baud_exponent - 3'h1); // [RL1] [RL5]
   // Framing of 1+8+1 bits lives in the host serial engine fed by this tick [RL2]
   // Rates above 1228.8 kbit/s are not guarded; software keeps to the limit [RL3]
   logic baud_tick;
   ckbd_div #(.W(16)) u_baud_div
   (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .ratio_in(baud_ratio),
      .tick_out(baud_tick)
   );
   // ----------------------------------------------------------------
   // PLL settings
   // ----------------------------------------------------------------
   wire logic [5:0] fb_factor =
      (pllc.pll_feedback_divider == 2'b01) ? CKBD_FB_27 :
      (pllc.pll_feedback_divider == 2'b10) ? CKBD_FB_28 : CKBD_FB_23; // [RL12]
   wire logic pdiv_bad = (pdiv < CKBD_PDIV_MIN) || (pdiv > CKBD_PDIV_MAX); // [RL13]
   // ----------------------------------------------------------------
   // Crystal fractions and timer toggles
   // ----------------------------------------------------------------
   // Pin cannot exceed half the system rate; x1 shows the halved crystal phase
   logic [2:0] xdiv;
   logic [CKBD_TIMERS-1:0] tmr_tgl;
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         xdiv <= 3'h0;
         tmr_tgl <= '0;
      end
      else
      begin
         xdiv <= xdiv + 3'h1;
         tmr_tgl <= tmr_tgl ^ timer_ovf_in; // [RL10]
      end
   end
   // PLL clock sampled through three stages; only stages 2 and 3 are looked at
   logic [2:0] pll_sync;
   logic pll_lvl;
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pll_sync <= 3'h0;
         pll_lvl <= 1'b0;
         pll_seen <= 1'b0;
         pdiv_bad_rd <= 1'b0;
      end
      else
      begin
         pll_sync <= {pll_sync[1:0], pll_clk_in};
         if (pll_sync[1] == pll_sync[2])
            pll_lvl <= pll_sync[2];
         pll_seen <= !pllc.pll_power_down && (pll_seen || pll_lvl);
         pdiv_bad_rd <= pdiv_bad;
      end
   end
   // ----------------------------------------------------------------
   // Clock pin source select
   // ----------------------------------------------------------------
   wire logic [3:0] sel = pllc.clock_pin_source_select;
   wire logic pll_ok = !pllc.pll_power_down && !pdiv_bad; // [RL15]
   logic next_pin;
   logic next_oe;
   always_comb
   begin
      next_oe = pllc.clock_pin_drive_enable; // [RL11]
      case (sel)
         CKBD_SRC_GPIO: next_pin = pin_gpio_in; // [RL8]
         CKBD_SRC_PLL: next_pin = pll_ok && pll_lvl; // [RL7]
         CKBD_SRC_LOW: next_pin = 1'b0;
         CKBD_SRC_HIGH: next_pin = 1'b1;
         CKBD_SRC_X1: next_pin = xdiv[0]; // [RL9]
         CKBD_SRC_X2: next_pin = xdiv[0];
         CKBD_SRC_X4: next_pin = xdiv[1];
         CKBD_SRC_X8: next_pin = xdiv[2];
         CKBD_SRC_T0: next_pin = tmr_tgl[0];
         CKBD_SRC_T1: next_pin = tmr_tgl[1];
         CKBD_SRC_T2: next_pin = tmr_tgl[2];
         CKBD_SRC_T3: next_pin = tmr_tgl[3];
         default: next_pin = 1'b0;
      endcase
      if (!pllc.clock_pin_drive_enable)
         next_pin = 1'b0;
   end
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         clock_output_pin_out <= 1'b0;
         clock_output_pin_oe_out <= 1'b0;
         baud_tick_out <= 1'b0;
         osc_trim_value_out <= CKBD_TRIM_RST;
         pll_fb_factor_out <= CKBD_FB_23;
         pll_out_ratio_out <= CKBD_PDIV_RST;
         pll_power_down_out <= 1'b0;
      end
      else
      begin
         clock_output_pin_out <= next_pin;
         clock_output_pin_oe_out <= next_oe;
         baud_tick_out <= baud_tick;
         osc_trim_value_out <= osc_trim_value; // [RL6]
         pll_fb_factor_out <= fb_factor; // [RL7]
         pll_out_ratio_out <= pdiv; // [RL13]
         pll_power_down_out <= pllc.pll_power_down; // [RL15]
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_baud_reset: assert property (@(posedge sys_clk_in) // [RL4]
      $rose(resetn_in) |-> baud == CKBD_BAUD_RST)
      else $error("baud setting not 7A after reset");
   a_write_baud: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL14]
      wr_baud |=> baud == $past(wb_dat_in[7:0]))
      else $error("baud write not stored");
   a_write_trim: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL6]
      wr_trim |=> osc_trim_value == $past(wb_dat_in[7:0]))
      else $error("trim write not stored");
   a_write_pdiv: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL13]
      wr_pdiv |=> pdiv == $past(wb_dat_in[7:0]))
      else $error("output ratio write not stored");
   a_ack_answer: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
      else $error("bus request not acknowledged");
   a_ack_single: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("acknowledge longer than one cycle");
   a_dat_idle: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !wb_ack_out |-> wb_dat_out == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");
   a_pin_disable: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL11]
      !pllc.clock_pin_drive_enable |=> !clock_output_pin_out && !clock_output_pin_oe_out)
      else $error("pin driven while disabled");
   a_oe_enable: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL11]
      pllc.clock_pin_drive_enable |=> clock_output_pin_oe_out)
      else $error("pin not driven while enabled");
   a_fb_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL12]
      pllc.pll_feedback_divider == 2'b00 |=> pll_fb_factor_out == CKBD_FB_23)
      else $error("feedback code 00 not 23");
   a_fb_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL12]
      pllc.pll_feedback_divider == 2'b01 |=> pll_fb_factor_out == CKBD_FB_27)
      else $error("feedback code 01 not 27");
   a_fb_mid: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL12]
      pllc.pll_feedback_divider == 2'b10 |=> pll_fb_factor_out == CKBD_FB_28)
      else $error("feedback code 10 not 28");
   a_fb_factor: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL12]
      pllc.pll_feedback_divider == 2'b11 |=> pll_fb_factor_out == CKBD_FB_23)
      else $error("feedback code 11 not 23");
   a_pin_gpio: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL8]
      (sel == 4'h0 && pllc.clock_pin_drive_enable) |=> clock_output_pin_out == $past(pin_gpio_in))
      else $error("pin does not follow general level");
   a_pin_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL8]
      (sel == 4'h2) |=> !clock_output_pin_out)
      else $error("pin not held low");
   a_pin_high: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL8]
      (sel == 4'h3 && pllc.clock_pin_drive_enable) |=> clock_output_pin_out)
      else $error("pin not held high");
   a_x_half: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL9]
      (sel == 4'h5 && pllc.clock_pin_drive_enable && $past(sel) == 4'h5
      && $past(pllc.clock_pin_drive_enable)) |=> clock_output_pin_out != $past(clock_output_pin_out))
      else $error("half crystal rate not toggling");
   a_reserved_src: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL10]
      (sel >= 4'hc) |=> !clock_output_pin_out)
      else $error("reserved source drives pin");
   // Toggle shows two edges after the pulse, so the source must hold one more cycle
   sequence s_t0_pulse;
      timer_ovf_in[0] && sel == 4'h8 && pllc.clock_pin_drive_enable;
   endsequence
   sequence s_t0_held;
      sel == 4'h8 && pllc.clock_pin_drive_enable;
   endsequence
   a_timer_tgl: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL10]
      s_t0_pulse ##1 s_t0_held |=> clock_output_pin_out != $past(clock_output_pin_out))
      else $error("timer toggle missing");
   a_pll_down: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL15]
      (sel == 4'h1 && pllc.pll_power_down) |=> !clock_output_pin_out)
      else $error("powered-down pll reaches pin");
   a_pd_copy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL15]
      1'b1 |=> pll_power_down_out == $past(pllc.pll_power_down))
      else $error("power down output lags setting");
   a_stat_pd: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL15]
      pllc.pll_power_down |=> !pll_seen)
      else $error("pll seen flag kept while powered down");
   a_trim_copy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL6]
      1'b1 |=> osc_trim_value_out == $past(osc_trim_value))
      else $error("trim output lags setting");
   a_ratio_copy: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL13]
      1'b1 |=> pll_out_ratio_out == $past(pdiv))
      else $error("ratio output lags setting");
   a_pll_ratio_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL13]
      (sel == 4'h1 && pdiv < CKBD_PDIV_MIN) |=> !clock_output_pin_out)
      else $error("reserved low ratio reaches pin");
   a_pll_ratio_high: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL13]
      (sel == 4'h1 && pdiv > CKBD_PDIV_MAX) |=> !clock_output_pin_out)
      else $error("reserved high ratio reaches pin");
   a_baud_ratio: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL1]
      baud == 8'h15 |-> baud_ratio == 16'h0016)
      else $error("baud ratio wrong for 15");
   a_baud_1c: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL5]
      baud == 8'h1c |-> baud_ratio == 16'h001d)
      else $error("baud ratio wrong for 1C");
   a_baud_5a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL5]
      baud == 8'h5a |-> baud_ratio == 16'h0076)
      else $error("baud ratio wrong for 5A");
   a_baud_7a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL5]
      baud == 8'h7a |-> baud_ratio == 16'h00ec)
      else $error("baud ratio wrong for 7A");
   a_baud_eb: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // [RL5]
      baud == 8'heb |-> baud_ratio == 16'h0b00)
      else $error("baud ratio wrong for EB");
endmodule
`default_nettype wire

// >>> dv/ckbd_clock_and_baud_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module ckbd_clock_and_baud_config_bench import ckbd_pkg::*; ;
   logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, pll_clk = 0, gpio = 0;
   logic [CKBD_ADDR_W-1:0] adr = '0;
   logic [3:0] sel = 4'h0, timer_ovf = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic ack, pin, pin_oe, tick, pd;
   logic [7:0] trim, ratio, v, e_rd;
   logic [5:0] fb;
   logic [7:0] exp_q[$];
   logic [5:0] fb_tab[4] = '{CKBD_FB_23, CKBD_FB_27, CKBD_FB_28, CKBD_FB_23};
   // Fastest entry is the top supported rate; nothing faster is programmed
   logic [7:0] baud_tab[5] = '{8'h15, 8'h1c, 8'h5a, 8'h7a, 8'heb};
   int baud_per[5] = '{22, 29, 118, 236, 2816};
   int rise_tab[4] = '{32, 32, 16, 8};
   int errors = 0, samples_checked = 0, seed = 41, n, k;
   logic p0;
   ckbd_clock_and_baud_config i_ckbd_clock_and_baud_config (.sys_clk_in(clk),
      .resetn_in(resetn), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .timer_ovf_in(timer_ovf), .pll_clk_in(pll_clk), .pin_gpio_in(gpio),
      .clock_output_pin_out(pin), .clock_output_pin_oe_out(pin_oe), .baud_tick_out(tick),
      .osc_trim_value_out(trim), .pll_fb_factor_out(fb), .pll_out_ratio_out(ratio),
      .pll_power_down_out(pd));
   always #5 clk = ~clk;
   // Foreign PLL clock, deliberately unrelated to the system clock
   always #7 pll_clk = ~pll_clk;
   // ----------------------------------------
   // Read data checker
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (ack === 1'b1 && we === 1'b0)
      begin
         if (exp_q.size() == 0)
            `CHK(1'b1, 1'b0)
         else
         begin
            // Pop once; the macro names its expected value twice
            e_rd = exp_q.pop_front();
            `CHK(rdat, {24'h00_0000, e_rd})
         end
      end
   end
   task automatic give_verdict();
      $display("Counts: %0d mismatches in %0d comparisons", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tk(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] s);
      int i;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      wdat <= {24'h00_0000, d};
      @(posedge clk);
      for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
      if (i == 20)
      begin
         errors++;
         give_verdict();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      wb(1'b0, idx, 8'h00, 4'hf);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, 4'h1);
   endtask
   // Bounded wait for one tick; a stuck divider ends the run
   task automatic wait_tick(output int c);
      c = 1;
      @(posedge clk);
      while (tick !== 1'b1 && c < 5000)
      begin
         @(posedge clk);
         c++;
      end
      if (c >= 5000)
      begin
         errors++;
         give_verdict();
      end
   endtask
   // 65 samples give exactly 64/period rises for any phase
   task automatic rises(output int r);
      logic prev;
      r = 0;
      prev = pin;
      repeat (64)
      begin
         @(posedge clk);
         if (pin === 1'b1 && prev === 1'b0) r++;
         prev = pin;
      end
   endtask
   task automatic pulse(input int t);
      timer_ovf <= 4'h1 << t;
      @(posedge clk);
      timer_ovf <= 4'h0;
      tk(4);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      tk(3);
      resetn <= 1'b1;
      @(posedge clk);
      `CHK({trim, fb, ratio, pd, pin_oe}, {CKBD_TRIM_RST, CKBD_FB_23, CKBD_PDIV_RST, 2'b00})
      rd(CKBD_IDX_BAUD, CKBD_BAUD_RST);
      rd(CKBD_IDX_TRIM, CKBD_TRIM_RST);
      rd(CKBD_IDX_PLLC, CKBD_PLLC_RST);
      rd(CKBD_IDX_PDIV, CKBD_PDIV_RST);
      v = 8'($random(seed));
      wr(CKBD_IDX_TRIM, v);
      rd(CKBD_IDX_TRIM, v);
      wb(1'b1, CKBD_IDX_TRIM, ~v, 4'h0);
      rd(CKBD_IDX_TRIM, v);
      `CHK(trim, v)
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      wr(CKBD_IDX_PDIV, CKBD_PDIV_MAX);
      rd(CKBD_IDX_PDIV, CKBD_PDIV_MAX);
      tk(2);
      `CHK(ratio, CKBD_PDIV_MAX)
      for (k = 0; k < 4; k++)
      begin
         wr(CKBD_IDX_PLLC, 8'(k));
         tk(2);
         `CHK(fb, fb_tab[k])
      end
      for (k = 0; k < 5; k++)
      begin
         wr(CKBD_IDX_BAUD, baud_tab[k]);
         wait_tick(n);
         wait_tick(n);
         wait_tick(n);
         `CHK(n, baud_per[k])
      end
      gpio <= 1'($random(seed));
      wr(CKBD_IDX_PLLC, 8'h08);
      tk(3);
      `CHK({pin, pin_oe}, {gpio, 1'b1})
      wr(CKBD_IDX_PLLC, 8'h28);
      tk(3);
      `CHK(pin, 1'b0)
      wr(CKBD_IDX_PLLC, 8'h38);
      tk(3);
      `CHK(pin, 1'b1)
      wr(CKBD_IDX_PLLC, 8'h30);
      tk(3);
      `CHK(pin_oe, 1'b0)
      for (k = 4; k < 8; k++)
      begin
         wr(CKBD_IDX_PLLC, {4'(k), 4'h8});
         tk(3);
         rises(n);
         `CHK(n, rise_tab[k-4])
      end
      wr(CKBD_IDX_PDIV, CKBD_PDIV_MIN);
      wr(CKBD_IDX_PLLC, 8'h18);
      tk(8);
      rises(n);
      `CHK(n > 0, 1'b1)
      rd(CKBD_IDX_STAT, 8'h01);
      wr(CKBD_IDX_PLLC, 8'h1c);
      tk(8);
      rises(n);
      `CHK({n == 0, pin, pd}, 3'b101)
      rd(CKBD_IDX_STAT, 8'h00);
      wr(CKBD_IDX_PDIV, 8'h07);
      wr(CKBD_IDX_PLLC, 8'h18);
      tk(8);
      rises(n);
      `CHK(n, 0)
      rd(CKBD_IDX_STAT, 8'h03);
      for (k = 0; k < 4; k++)
      begin
         wr(CKBD_IDX_PLLC, {4'(k + 8), 4'h8});
         tk(3);
         p0 = pin;
         pulse(k);
         `CHK(pin, ~p0)
         pulse((k + 1) % 4);
         `CHK(pin, ~p0)
      end
      give_verdict();
   end
endmodule
`default_nettype wire
